// ===== pipelined_burst_sram_port.sv
// Pipelined burst static memory port: command pipeline, burst counter, byte writes, sleep.
// Assumes the host drives all synchronous pins from ref_clk; the sleep and order pins are
// asynchronous and are synchronised here.
`timescale 1ns/10ps

// What this block does
// (RULE1) Sample inputs and drive outputs on rising edge
// (RULE2) Clock-qualify high freezes all state except the sleep sequencer and pin synchronisers
// (RULE3) Selected, write-select high, load low starts read
// (RULE4) Read data appears after the following edge
// (RULE5) Output-drive input gates read data drivers
// (RULE6) New command accepted right after a read
// (RULE7) Deselect tri-states outputs after next edge
// (RULE8) Burst counter varies two low bits, wraps
// (RULE9) Order strap low linear, high interleaved
// (RULE10) Interleaved order XORs start with beat
// (RULE11) Linear order counts upward modulo four
// (RULE12) Advance high increments counter, ignores selects
// (RULE13) Read or write type kept whole burst
// (RULE14) Selected with write-select low starts write
// (RULE15) Edge after write command tri-states data lanes
// (RULE16) Write data latched second edge after command
// (RULE17) Only selected byte lanes are written
// (RULE18) Host must not drive lanes while outputs on
// (RULE19) Host drives byte selects every burst beat
// (RULE20) Host loads fresh address after deselect
// (RULE21) Sleep entry and exit take two cycles
// (RULE22) Accesses pending at sleep entry are dropped
// (RULE23) Host deselects around sleep and recovery
// (RULE24) Order strap defaults to interleaved
// (RULE25) Comes up deselected with lanes tri-stated
// (RULE26) Selects active: first low, second high, third low
module pipelined_burst_sram_port
	import sram_port_pkg::*;
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	// Command pins
	input  wire logic              clock_qualify_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              advance_or_load,
	input  wire logic              writeSelectN,
	input  wire logic [LANES-1:0]  byte_lane_write_n,
	input  wire logic              chip_select_first_n,
	input  wire logic              chip_select_second,
	input  wire logic              chip_select_third_n,
	input  wire logic              outputDriveN,
	// Asynchronous pins
	input  wire logic              sleep_request,
	input  wire logic              burstOrderStrap,
	// Data lanes
	input  wire logic [DATA_W-1:0] dataIn,
	output logic      [DATA_W-1:0] dataOut,
	output logic                   dataOe,
	// Parity lanes
	input  wire logic [LANES-1:0]  parity_lanes_in,
	output logic      [LANES-1:0]  parity_lanes_out,
	output logic                   parityOe
);

	// --------------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------------
	function automatic logic [WORD_W-1:0] packWord(input logic [DATA_W-1:0] d,
	                                               input logic [LANES-1:0] p);
		logic [WORD_W-1:0] w;
		w = '0;
		for (int i = 0; i < LANES; i++) begin
			w[i*LANE_W +: LANE_W] = {p[i], d[i*BYTE_W +: BYTE_W]};
		end
		return w;
	endfunction

	function automatic logic [WORD_W-1:0] mergeLanes(input logic [WORD_W-1:0] old,
	                                                 input logic [WORD_W-1:0] fresh,
	                                                 input logic [LANES-1:0] laneN);
		logic [WORD_W-1:0] w;
		w = old;
		for (int i = 0; i < LANES; i++) begin
			if (!laneN[i]) begin
				w[i*LANE_W +: LANE_W] = fresh[i*LANE_W +: LANE_W];
			end
		end
		return w;
	endfunction

	// --------------------------------------------------------------------
	// State
	// --------------------------------------------------------------------
	logic [WORD_W-1:0] mem [DEPTH];
	logic [2:0]        sleepSync;
	logic              sleepLevel;
	logic [2:0]        orderSync;
	logic              orderInterleaved;
	sleep_state_type   sleepState;
	logic [CNT_W-1:0]  sleepCount;
	front_type         front;
	back_type          back;

	logic              running;
	logic              accept;
	logic              selActive;
	logic [LOW_W-1:0]  frontLow;
	logic [ADDR_W-1:0] frontAddr;
	logic [WORD_W-1:0] incoming;
	logic [WORD_W-1:0] backOld;
	logic [WORD_W-1:0] readWord;
	logic              commit;

	// --------------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sleepSync  <= SLEEP_SYNC_RESET;
			sleepLevel <= 1'b0;
		end else begin
			sleepSync <= {sleepSync[1:0], sleep_request};
			if (sleepSync[1] == sleepSync[2]) begin
				sleepLevel <= sleepSync[2];
			end
		end
	end

	// Strap reads as interleaved until a settled low is seen
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			orderSync        <= ORDER_SYNC_RESET;
			orderInterleaved <= ORDER_INTERLEAVED;	// see (RULE24)
		end else begin
			orderSync <= {orderSync[1:0], burstOrderStrap};
			if (orderSync[1] == orderSync[2]) begin
				orderInterleaved <= orderSync[2];	// see (RULE9)
			end
		end
	end

	// --------------------------------------------------------------------
	// Sleep sequencing
	// --------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sleepState <= S_AWAKE;
			sleepCount <= CNT_ZERO;
		end else begin
			case (sleepState)
				S_AWAKE: begin
					if (sleepLevel) begin
						sleepState <= S_ENTERING;	// see (RULE21)
						sleepCount <= ENTRY_LOAD;
					end
				end
				S_ENTERING: begin
					if (sleepCount == CNT_ZERO) begin
						sleepState <= S_ASLEEP;
					end else begin
						sleepCount <= sleepCount - CNT_STEP;
					end
				end
				S_ASLEEP: begin
					if (!sleepLevel) begin
						sleepState <= S_WAKING;	// see (RULE21)
						sleepCount <= RECOVERY_LOAD;
					end
				end
				S_WAKING: begin
					if (sleepCount == CNT_ZERO) begin
						sleepState <= S_AWAKE;
					end else begin
						sleepCount <= sleepCount - CNT_STEP;
					end
				end
				default: begin
					sleepState <= S_AWAKE;
					sleepCount <= CNT_ZERO;
				end
			endcase
		end
	end

	// --------------------------------------------------------------------
	// Command decode
	// --------------------------------------------------------------------
	assign running   = (sleepState == S_AWAKE);
	assign accept    = running && !clock_qualify_n;	// see (RULE2)
	assign selActive = !chip_select_first_n && chip_select_second
	                   && !chip_select_third_n;	// see (RULE26)

	burst_sequencer u_seq (
		.startLow    (front.base[LOW_W-1:0]),
		.beat        (front.beat),
		.interleaved (orderInterleaved),
		.addrLow     (frontLow)
	);

	// Only the two low bits move during a burst
	assign frontAddr = {front.base[ADDR_W-1:LOW_W], frontLow};	// see (RULE8)
	assign incoming  = packWord(dataIn, parity_lanes_in);
	assign backOld   = mem[back.addr];
	assign commit    = accept && back.active && back.write;

	// Forward a write committing on the same edge as a read of that word
	always_comb begin
		readWord = mem[frontAddr];
		if (back.active && back.write && back.addr == frontAddr) begin
			readWord = mergeLanes(readWord, incoming, back.laneWriteN);
		end
	end

	// --------------------------------------------------------------------
	// Command and burst stage
	// --------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			front <= FRONT_IDLE;	// see (RULE25)
		end else if (!running) begin
			front <= FRONT_IDLE;	// see (RULE22)
		end else if (accept) begin	// see (RULE1)
			if (advance_or_load) begin
				// Selects and write select ignored while advancing
				front.beat       <= front.beat + BEAT_STEP;	// see (RULE12)
				front.laneWriteN <= byte_lane_write_n;	// see (RULE19)
			end else if (selActive) begin
				front.active     <= 1'b1;	// see (RULE3)
				front.write      <= !writeSelectN;	// see (RULE14) (RULE13)
				front.base       <= addr;
				front.beat       <= BEAT_FIRST;
				front.laneWriteN <= byte_lane_write_n;
			end else begin
				front <= FRONT_IDLE;	// see (RULE20)
			end
		end
	end

	// --------------------------------------------------------------------
	// Write data stage
	// --------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			back <= BACK_IDLE;
		end else if (!running) begin
			back <= BACK_IDLE;	// see (RULE22)
		end else if (accept) begin
			back.active     <= front.active;
			back.write      <= front.write;
			back.addr       <= frontAddr;
			back.laneWriteN <= front.laneWriteN;
		end
	end

	// Core write on the second edge after the command
	always_ff @(posedge ref_clk) begin
		if (commit) begin
			mem[back.addr] <= mergeLanes(backOld, incoming, back.laneWriteN);	// see (RULE16) (RULE17)
		end
	end

	// --------------------------------------------------------------------
	// Output register
	// --------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			dataOut          <= '0;
			parity_lanes_out <= '0;
			dataOe           <= 1'b0;	// see (RULE25)
			parityOe         <= 1'b0;
		end else if (!running) begin
			dataOe   <= 1'b0;
			parityOe <= 1'b0;
		end else if (accept) begin
			for (int i = 0; i < LANES; i++) begin
				dataOut[i*BYTE_W +: BYTE_W] <= readWord[i*LANE_W +: BYTE_W];	// see (RULE4)
				parity_lanes_out[i]         <= readWord[i*LANE_W + BYTE_W];
			end
			// Writes and deselects tri-state; reads obey output drive
			dataOe   <= front.active && !front.write && !outputDriveN;	// see (RULE5) (RULE7) (RULE15)
			parityOe <= front.active && !front.write && !outputDriveN;	// see (RULE6)
		end
	end

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	sequence readIssued;
		accept && !advance_or_load && selActive && writeSelectN;
	endsequence

	sequence writeIssued;
		accept && !advance_or_load && selActive && !writeSelectN;
	endsequence

	sequence nextDriven;
		accept && !outputDriveN;
	endsequence

	a_read_latency: assert property (readIssued ##1 nextDriven |=> dataOe && parityOe) // see (RULE4)
		else $error("read data not driven one cycle after command");

	a_read_pipelined: assert property (readIssued ##1 accept |=> front.active || !dataOe) // see (RULE6)
		else $error("command after read not taken");

	a_stall_holds: assert property (running && clock_qualify_n |=> // see (RULE2)
		$stable(front) && $stable(back) && $stable(dataOe) && $stable(dataOut))
		else $error("state moved on a stalled edge");

	a_deselect_pipe: assert property (accept && !advance_or_load && !selActive ##1 accept // see (RULE7)
		|=> !dataOe)
		else $error("outputs still on after deselect");

	a_write_tristate: assert property (writeIssued ##1 accept |=> !dataOe && !parityOe) // see (RULE15)
		else $error("lanes driven during write data cycle");

	a_lane_written: assert property (commit && !back.laneWriteN[0] |=> // see (RULE16)
		mem[$past(back.addr)][LANE_W-1:0] == $past(incoming[LANE_W-1:0]))
		else $error("selected lane not written");

	a_lane_kept: assert property (commit && back.laneWriteN[0] |=> // see (RULE17)
		mem[$past(back.addr)][LANE_W-1:0] == $past(backOld[LANE_W-1:0]))
		else $error("unselected lane altered");

	a_burst_linear: assert property (accept && advance_or_load && front.active // see (RULE11)
		&& !orderInterleaved ##1 !orderInterleaved |->
		frontAddr[LOW_W-1:0] == $past(frontAddr[LOW_W-1:0]) + BEAT_STEP)
		else $error("linear burst step wrong");

	a_burst_interleave: assert property (front.active && orderInterleaved |-> // see (RULE10)
		frontAddr[LOW_W-1:0] == (front.base[LOW_W-1:0] ^ front.beat))
		else $error("interleaved burst address wrong");

	a_burst_upper: assert property (accept && advance_or_load && front.active |=> // see (RULE8)
		$stable(frontAddr[ADDR_W-1:LOW_W]))
		else $error("burst moved upper address bits");

	a_type_kept: assert property (accept && advance_or_load && front.active |=> // see (RULE13)
		front.write == $past(front.write) && front.active)
		else $error("burst changed access type");

	a_sleep_entry: assert property (sleepState == S_AWAKE && sleepLevel |=> // see (RULE21)
		sleepState == S_ENTERING ##1 sleepState == S_ENTERING ##1 sleepState == S_ASLEEP)
		else $error("sleep entry not two cycles");

	a_sleep_exit: assert property (sleepState == S_ASLEEP && !sleepLevel |=> // see (RULE21)
		(sleepState == S_WAKING) [*2] ##1 sleepState == S_AWAKE)
		else $error("sleep exit not two cycles");

	a_sleep_quiet: assert property (!running |=> !dataOe && !front.active && !back.active) // see (RULE22)
		else $error("access survived sleep");

endmodule

// ===== sram_port_pkg.sv
// Shared widths, field layouts, reset values and timing counts for the burst memory port.
// Assumes a single 125 MHz core clock; the host runs on that same clock.
package sram_port_pkg;

	// --------------------------------------------------------------------
	// Geometry
	// --------------------------------------------------------------------
	localparam int ADDR_W   = 19;
	localparam int LANES    = 4;
	localparam int BYTE_W   = 8;
	localparam int LANE_W   = BYTE_W + 1;
	localparam int DATA_W   = LANES * BYTE_W;
	localparam int WORD_W   = LANES * LANE_W;
	localparam int DEPTH    = 1 << ADDR_W;
	localparam int LOW_W    = 2;
	localparam int CNT_W    = 2;

	// --------------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------------
	localparam int CLK_PERIOD_NS        = 8;
	localparam int SLEEP_ENTRY_TIME_NS  = 2 * CLK_PERIOD_NS;
	localparam int SLEEP_RECOVERY_TIME_NS = 2 * CLK_PERIOD_NS;
	localparam int SLEEP_ENTRY_CYCLES   = SLEEP_ENTRY_TIME_NS / CLK_PERIOD_NS;
	localparam int SLEEP_RECOVERY_CYCLES =
		(SLEEP_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [CNT_W-1:0] ENTRY_LOAD    = CNT_W'(SLEEP_ENTRY_CYCLES - 1);
	localparam logic [CNT_W-1:0] RECOVERY_LOAD = CNT_W'(SLEEP_RECOVERY_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO      = 2'h0;
	localparam logic [CNT_W-1:0] CNT_STEP      = 2'h1;

	// --------------------------------------------------------------------
	// Burst and reset values
	// --------------------------------------------------------------------
	localparam logic [LOW_W-1:0] BEAT_FIRST = 2'h0;
	localparam logic [LOW_W-1:0] BEAT_STEP  = 2'h1;
	localparam logic             ORDER_INTERLEAVED = 1'h1;
	localparam logic [2:0]       SLEEP_SYNC_RESET  = 3'h0;
	localparam logic [2:0]       ORDER_SYNC_RESET  = 3'h7;

	typedef enum logic [1:0] {
		S_AWAKE,
		S_ENTERING,
		S_ASLEEP,
		S_WAKING
	} sleep_state_type;

	// Loaded command with its burst position
	typedef struct packed {
		logic              active;
		logic              write;
		logic [ADDR_W-1:0] base;
		logic [LOW_W-1:0]  beat;
		logic [LANES-1:0]  laneWriteN;
	} front_type;

	// Beat waiting for its write data
	typedef struct packed {
		logic              active;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0]  laneWriteN;
	} back_type;

	localparam front_type FRONT_IDLE = '0;
	localparam back_type  BACK_IDLE  = '0;

endpackage

// ===== burst_sequencer.sv
// Burst address low-bit generator for the memory port.
// Pure combinational; the caller holds start bits and beat number in registers.
`timescale 1ns/10ps

module burst_sequencer
	import sram_port_pkg::*;
(
	// Burst position
	input  wire logic [LOW_W-1:0] startLow,
	input  wire logic [LOW_W-1:0] beat,
	input  wire logic             interleaved,
	// Address low bits for this beat
	output logic      [LOW_W-1:0] addrLow
);

	always_comb begin
		if (interleaved) begin
			addrLow = startLow ^ beat;	// see (RULE10)
		end else begin
			addrLow = startLow + beat;	// see (RULE11)
		end
	end

endmodule

// ===== host_model.sv
// Host controller model: drives the command pins and the write data lanes.
// Assumes the bench calls beat once a cycle, just after the clock rise.
`timescale 1ns/10ps

module host_model
	import sram_port_pkg::*;
(
	// Clock
	input  wire logic              ref_clk,
	// Command pins
	output logic                   clock_qualify_n,
	output logic [ADDR_W-1:0]      addr,
	output logic                   advance_or_load,
	output logic                   writeSelectN,
	output logic [LANES-1:0]       byte_lane_write_n,
	output logic                   chip_select_first_n,
	output logic                   chip_select_second,
	output logic                   chip_select_third_n,
	output logic                   outputDriveN,
	// Asynchronous pins
	output logic                   sleep_request,
	output logic                   burstOrderStrap,
	// Write data
	output logic [DATA_W-1:0]      dataIn,
	output logic [LANES-1:0]       parity_lanes_in
);
	logic [WORD_W-1:0] stage1, stage2, lastBus, curWord, held;
	logic              v1, v2, take, heldWrite, curWrite, burstWrite;

	// --------------------------------------------------------------------
	// Write data, two accepted edges after its beat
	// --------------------------------------------------------------------
	// Released lanes show the inverse of the last driven word
	assign {parity_lanes_in, dataIn} = v2 ? stage2 : ~lastBus;
	always begin
		@(posedge ref_clk);
		take = !clock_qualify_n;
		heldWrite = curWrite;
		held = curWord;
		#1;
		if (take) begin
			v2 = v1;
			stage2 = stage1;
			v1 = heldWrite;
			stage1 = held;
		end
		if (v2) begin
			lastBus = stage2;
		end
	end

	initial begin
		{v1, v2, curWrite, burstWrite, clock_qualify_n, advance_or_load} = '0;
		{stage1, stage2, lastBus, curWord, addr} = '0;
		{writeSelectN, chip_select_first_n, burstOrderStrap} = 3'h7;
		{chip_select_second, chip_select_third_n, outputDriveN, sleep_request} = 4'h0;
		byte_lane_write_n = 4'hf;
	end

	// --------------------------------------------------------------------
	// One cycle of commands: 0 deselect, 1 read, 2 write, 3 advance, 4 stall
	// --------------------------------------------------------------------
	task beat(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] bw,
		input logic [WORD_W-1:0] wd, input logic odn);
		clock_qualify_n = (op == 3'h4);
		advance_or_load = (op == 3'h3);
		addr = a;
		byte_lane_write_n = bw;
		outputDriveN = odn;
		// Advance flips the type pin and drops a select; both must be ignored
		writeSelectN = (op == 3'h3) ? burstWrite : (op != 3'h2 && op != 3'h4);
		chip_select_first_n = (op == 3'h3) || (op == 3'h0 && a[1:0] == 2'h0);
		chip_select_second = !(op == 3'h0 && a[1:0] == 2'h1);
		chip_select_third_n = (op == 3'h0 && a[1]);
		if (op == 3'h1 || op == 3'h2) begin
			burstWrite = (op == 3'h2);
		end
		curWrite = (op == 3'h2) || (op == 3'h3 && burstWrite);
		curWord = wd;
	endtask
endmodule

// ===== test_pipelined_burst_sram_port.sv
// Self-checking bench for the burst memory port, with a host model on its pins.
// Assumes the one 125 MHz clock and the host model beside the port.
`timescale 1ns/10ps

module test_pipelined_burst_sram_port
	import sram_port_pkg::*;
;
	localparam logic [2:0] DES = 3'h0, RD = 3'h1, WR = 3'h2, ADV = 3'h3, STL = 3'h4;
	typedef struct packed {
		logic [2:0] op;
		logic [2:0] a;
		logic [3:0] bw;
		logic       odn;
	} row_type;

	logic              ref_clk, resetn, clock_qualify_n, advance_or_load, writeSelectN;
	logic              chip_select_first_n, chip_select_second, chip_select_third_n;
	logic              outputDriveN, sleep_request, burstOrderStrap, dataOe, parityOe;
	logic [ADDR_W-1:0] addr, base;
	logic [LANES-1:0]  byte_lane_write_n, parity_lanes_in, parity_lanes_out;
	logic [DATA_W-1:0] dataIn, dataOut;
	logic [WORD_W-1:0] mem [int];
	logic [WORD_W-1:0] expWord, prevOut;
	logic [1:0]        beatNo;
	logic              inBurst, isWrite, interleave, asleep, expRead, prevOe;
	int                err_count, check_count, seq;

	row_type rows [23] = '{
		'{WR, 3'h0, 4'h0, 1'b0}, '{WR, 3'h1, 4'h0, 1'b0}, '{WR, 3'h2, 4'h0, 1'b0},
		'{WR, 3'h3, 4'h0, 1'b0}, '{RD, 3'h1, 4'hf, 1'b0}, '{ADV, 3'h0, 4'hf, 1'b0},
		'{ADV, 3'h0, 4'hf, 1'b0}, '{ADV, 3'h0, 4'hf, 1'b0}, '{ADV, 3'h0, 4'hf, 1'b0},
		'{WR, 3'h2, 4'ha, 1'b0}, '{RD, 3'h2, 4'hf, 1'b0}, '{STL, 3'h0, 4'h0, 1'b0},
		'{DES, 3'h1, 4'hf, 1'b0}, '{ADV, 3'h0, 4'hf, 1'b0}, '{RD, 3'h0, 4'hf, 1'b0},
		'{ADV, 3'h0, 4'hf, 1'b1}, '{DES, 3'h0, 4'hf, 1'b0}, '{WR, 3'h3, 4'h0, 1'b0},
		'{ADV, 3'h0, 4'h3, 1'b0}, '{ADV, 3'h0, 4'hf, 1'b0}, '{RD, 3'h2, 4'hf, 1'b0},
		'{ADV, 3'h0, 4'hf, 1'b0}, '{DES, 3'h2, 4'hf, 1'b0}
	};

	pipelined_burst_sram_port pipelined_burst_sram_port_inst (.ref_clk, .resetn,
		.clock_qualify_n, .addr, .advance_or_load, .writeSelectN, .byte_lane_write_n,
		.chip_select_first_n, .chip_select_second, .chip_select_third_n, .outputDriveN,
		.sleep_request, .burstOrderStrap, .dataIn, .dataOut, .dataOe, .parity_lanes_in,
		.parity_lanes_out, .parityOe);
	host_model host_model_inst (.ref_clk, .clock_qualify_n, .addr, .advance_or_load,
		.writeSelectN, .byte_lane_write_n, .chip_select_first_n, .chip_select_second,
		.chip_select_third_n, .outputDriveN, .sleep_request, .burstOrderStrap, .dataIn,
		.parity_lanes_in);

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	initial begin
		#100000;
		err_count++;
		complete_run();
	end

	// --------------------------------------------------------------------
	// Checking helpers
	// --------------------------------------------------------------------
	task complete_run();
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function logic [ADDR_W-1:0] beatAddr();
		logic [1:0] low;
		low = interleave ? base[1:0] ^ beatNo : base[1:0] + beatNo;
		return {base[ADDR_W-1:2], low};
	endfunction

	// One cycle: drive, model the beat, then check the previous beat's output
	task step(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic [3:0] bw,
		input logic odn);
		logic [WORD_W-1:0] wd, nw;
		logic [ADDR_W-1:0] ba;
		logic              nr;
		seq++;
		wd = {seq[3:0], seq[7:0] * 32'h01010101 ^ 32'h13579bdf};
		host_model_inst.beat(op, a, bw, wd, odn);
		nr = 1'b0;
		nw = '0;
		if (!asleep && op != STL) begin
			if (op == RD || op == WR) begin
				base = a;
				beatNo = 2'h0;
				inBurst = 1'b1;
				isWrite = (op == WR);
			end else if (op == ADV) begin
				beatNo = beatNo + 2'h1;
			end else begin
				inBurst = 1'b0;
			end
			if (inBurst) begin
				ba = beatAddr();
				if (isWrite) begin
					for (int i = 0; i < LANES; i++) begin
						if (!bw[i]) begin
							mem[ba][8*i+:8] = wd[8*i+:8];
							mem[ba][DATA_W+i] = wd[DATA_W+i];
						end
					end
				end else begin
					nr = 1'b1;
					nw = mem[ba];
				end
			end
		end
		@(posedge ref_clk);
		#1;
		if (op == STL) begin
			check({parity_lanes_out, dataOut}, prevOut);
			check(dataOe, prevOe);
		end else begin
			check(dataOe, expRead & !odn);
			check(parityOe, expRead & !odn);
			if (expRead & !odn) begin
				check({parity_lanes_out, dataOut}, expWord);
			end
			expRead = nr;
			expWord = nw;
		end
		prevOut = {parity_lanes_out, dataOut};
		prevOe = dataOe;
	endtask

	// --------------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------------
	initial begin
		{resetn, seq, err_count, check_count, inBurst, isWrite, expRead, asleep} = '0;
		{base, beatNo, expWord, prevOut, prevOe} = '0;
		interleave = 1'b1;
		repeat (20) @(posedge ref_clk);
		#1;
		check(dataOe, 1'b0);
		check(parityOe, 1'b0);
		resetn = 1'b1;
		foreach (rows[i]) begin
			step(rows[i].op, {16'h0020, rows[i].a}, rows[i].bw, rows[i].odn);
		end
		// Linear order once the strap has settled low
		host_model_inst.burstOrderStrap = 1'b0;
		interleave = 1'b0;
		repeat (5) step(DES, '0, 4'hf, 1'b0);
		step(RD, 19'h00101, 4'hf, 1'b0);
		repeat (3) step(ADV, '0, 4'hf, 1'b0);
		repeat (2) step(DES, '0, 4'hf, 1'b0);
		// Commands while asleep are dropped; stored data survives
		host_model_inst.sleep_request = 1'b1;
		repeat (8) step(DES, '0, 4'hf, 1'b0);
		asleep = 1'b1;
		step(WR, 19'h00100, 4'h0, 1'b0);
		step(RD, 19'h00100, 4'hf, 1'b0);
		host_model_inst.sleep_request = 1'b0;
		repeat (8) step(DES, '0, 4'hf, 1'b0);
		asleep = 1'b0;
		step(RD, 19'h00100, 4'hf, 1'b0);
		step(DES, '0, 4'hf, 1'b0);
		complete_run();
	end
endmodule
